// ---- design/asq_sequencer.sv ----
`timescale 1ns/1ps
`include "asq_regs.svh"
module asq_sequencer
    import asq_pkg::*;
#(
    parameter int NUM_CH = 16
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        cs_n_in,
    input  wire logic        sclk_in,
    input  wire logic        din_in,
    input  wire logic        convert_start_n_in,
    input  wire logic [11:0] result_in,
    input  wire logic        result_valid_in,
    output logic             result_ready_out,
    output logic             dout_out,
    output logic             eoc_n_out,
    output logic             sample_out,
    output logic [3:0]       mux_chan_out,
    output logic [4:0]       fifo_count_out
);
    localparam logic [3:0] TOP_CH  = 4'(NUM_CH - 1);
    localparam logic [3:0] OSC_END = 4'(`ASQ_OSC_DIV - 1);
    localparam logic [2:0] CNV_MIN = 3'(`ASQ_CNV_LOW_CYC);
    localparam logic [4:0] FIFO_FULL = 5'(`ASQ_FIFO_DEPTH);

    asq_state_t s;
    asq_state_t n;
    logic [3:0] pins;
    logic [3:0] chg;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cnv_rise;
    logic       cnv_fall;
    logic       is_int;
    logic       is_ext_scan;
    logic       step13;
    logic       load_evt;
    logic       pop;
    logic       drain;

    assign pins = {convert_start_n_in, din_in, sclk_in, cs_n_in};

    // Change accepted once second and third stages agree
    genvar g;
    for (g = 0; g < 4; g++) begin : g_sync
        assign chg[g] = (s.sy[g][1] == s.sy[g][2]) && (s.sy[g][2] != s.lvl[g]);
    end

    assign cs_fall   = chg[0] && !s.sy[0][2];
    assign cs_rise   = chg[0] && s.sy[0][2];
    assign sclk_rise = chg[1] && s.sy[1][2] && !s.lvl[0];
    assign sclk_fall = chg[1] && !s.sy[1][2] && !s.lvl[0];
    assign cnv_rise  = chg[3] && s.sy[3][2];
    assign cnv_fall  = chg[3] && !s.sy[3][2];

    assign is_int = (s.scan == ASQ_REPEAT) || (s.scan == ASQ_STD_INT) ||
                    (s.scan == ASQ_UP_INT) || (s.scan == ASQ_CUST_INT);
    assign is_ext_scan = (s.scan == ASQ_STD_EXT) || (s.scan == ASQ_UP_EXT) ||
                         (s.scan == ASQ_CUST_EXT) || (s.scan == ASQ_SEQ);
    assign step13 = sclk_fall && (s.fcnt == 5'(`ASQ_MUX_STEP_FALL - 1));
    assign load_evt = is_int && ((cs_fall && !s.echo_pend) ||
                                 (sclk_fall && s.fcnt == 5'h07 && !s.echo_fr));
    assign pop   = load_evt && s.byte_lo && (s.cnt != 5'h00);
    // Reading and writing the FIFO in one cycle is avoided by stalling the drain
    assign drain = (s.buf_cnt != 2'h0) && !pop;

    function automatic logic [3:0] asq_first(input logic [3:0] scan, input logic [3:0] chsel,
                                             input logic [15:0] mask, input logic [3:0] seq0);
        logic [3:0] r;
        r = chsel;
        case (scan)
            ASQ_STD_INT, ASQ_STD_EXT: r = 4'h0;
            ASQ_CUST_INT, ASQ_CUST_EXT: begin
                for (int i = 15; i >= 0; i--) begin
                    if (mask[i]) r = 4'(i);
                end
            end
            ASQ_SEQ: r = seq0;
            default: r = chsel;
        endcase
        return r;
    endfunction : asq_first

    // Returns {done, next channel}
    function automatic logic [4:0] asq_next(input logic [3:0] scan, input logic [3:0] cur,
                                            input logic [3:0] chsel, input logic [15:0] mask);
        logic [4:0] r;
        r = {1'b1, cur};
        case (scan)
            ASQ_STD_INT, ASQ_STD_EXT: begin
                if (cur < chsel) r = {1'b0, 4'(cur + 4'h1)};
            end
            ASQ_UP_INT, ASQ_UP_EXT: begin
                if (cur < TOP_CH) r = {1'b0, 4'(cur + 4'h1)};
            end
            ASQ_CUST_INT, ASQ_CUST_EXT: begin
                for (int i = 15; i >= 0; i--) begin
                    if (4'(i) > cur && mask[i]) r = {1'b0, 4'(i)};
                end
            end
            default: r = {1'b1, cur};
        endcase
        return r;
    endfunction : asq_next

    always_comb begin
        logic [4:0]  nx;
        logic [15:0] w;
        logic [7:0]  bsel;
        logic [`ASQ_SEQ_AW-1:0] sidx;
        nx   = 5'h00;
        w    = 16'h0000;
        bsel = 8'h00;
        sidx = '0;
        n = s;
        n.sample = 1'b0;
        for (int i = 0; i < 4; i++) begin
            n.sy[i] = {s.sy[i][1:0], pins[i]};
            if (chg[i]) n.lvl[i] = s.sy[i][2];
        end
        n.cnv_low = s.lvl[3] ? 3'h0 : ((s.cnv_low == 3'h7) ? s.cnv_low : 3'(s.cnv_low + 3'h1));
        n.osc_cnt = (s.osc_cnt == OSC_END) ? 4'h0 : 4'(s.osc_cnt + 4'h1);

        // Two-entry result buffer, filling side
        if (result_valid_in && s.buf_cnt != 2'h2) begin
            n.buf_mem[s.buf_wr] = {s.conv_chan, result_in};
            n.buf_wr = !s.buf_wr;
        end
        n.buf_cnt = 2'(s.buf_cnt + {1'b0, (result_valid_in && s.buf_cnt != 2'h2)} - {1'b0, drain});

        // Frame start
        if (cs_fall) begin
            n.rcnt    = 5'h00;
            n.fcnt    = 5'h00;
            n.eoc_n   = 1'b1;
            n.echo_fr = s.echo_pend;
            if (s.echo_pend) begin
                n.tx        = {`ASQ_SEL_CFG, s.cfg};
                n.echo_pend = 1'b0;
            end else if (!is_int) begin
                n.tx = s.ext_res;
            end
            if (!is_int) begin
                n.sample    = 1'b1;
                n.conv_chan = s.mux;
            end
        end
        if (cnv_fall) n.eoc_n = 1'b1;
        if (sclk_rise) begin
            n.rx   = {s.rx[14:0], s.lvl[2]};
            n.rcnt = (s.rcnt == 5'h1F) ? s.rcnt : 5'(s.rcnt + 5'h01);
        end
        if (sclk_fall) begin
            n.tx   = {s.tx[14:0], 1'b0};
            n.fcnt = (s.fcnt == 5'h1F) ? s.fcnt : 5'(s.fcnt + 5'h01);
        end

        // Byte readout from FIFO, oldest first, high byte with tag first
        if (load_evt) begin
            bsel = s.byte_lo ? s.fifo_mem[s.rd][7:0] : s.fifo_mem[s.rd][15:8];
            if (s.cnt == 5'h00) begin
                n.tx = 16'h0000;
            end else begin
                n.tx      = {bsel, 8'h00};
                n.byte_lo = !s.byte_lo;
            end
        end
        if (pop) begin
            n.rd  = 4'(s.rd + 4'h1);
            n.cnt = 5'(s.cnt - 5'h01);
        end

        // Thirteenth fall steps the mux in external scans
        if (step13 && is_ext_scan) begin
            if (s.scan == ASQ_SEQ) begin
                if (s.seq_len != '0) begin
                    sidx = ({1'b0, s.seq_idx} == 9'(s.seq_len - 9'h001)) ? '0
                           : 8'(s.seq_idx + 8'h01);
                    n.seq_idx = sidx;
                    n.mux     = s.seq_mem[sidx];
                end
            end else begin
                nx    = asq_next(s.scan, s.mux, s.chsel, s.cust);
                n.mux = nx[4] ? asq_first(s.scan, s.chsel, s.cust, s.seq_mem[0]) : nx[3:0];
            end
        end

        // Internal scan pacing
        if (s.phase == ASQ_ST_TICK && s.osc_cnt == OSC_END) begin
            n.sample    = 1'b1;
            n.conv_chan = s.mux;
            n.phase     = ASQ_ST_WAIT;
        end

        // Buffer drain: FIFO during internal scans, else next-frame result
        if (drain) begin
            w = s.buf_mem[s.buf_rd];
            n.buf_rd = !s.buf_rd;
            if (s.phase == ASQ_ST_WAIT) begin
                n.fifo_mem[s.wr] = w;
                n.wr = 4'(s.wr + 4'h1);
                if (s.cnt == FIFO_FULL) begin
                    n.rd      = 4'(s.rd + 4'h1);
                    n.byte_lo = 1'b0;
                end else begin
                    n.cnt = 5'(s.cnt + 5'h01);
                end
                nx = asq_next(s.scan, s.mux, s.chsel, s.cust);
                if (s.scan == ASQ_REPEAT) nx = {(s.rep_left == 4'h0), s.mux};
                if (nx[4]) begin
                    n.phase = ASQ_ST_IDLE;
                    n.eoc_n = 1'b0;
                    n.software_convert_bit = 1'b0;
                end else begin
                    n.mux      = nx[3:0];
                    n.rep_left = 4'(s.rep_left - 4'h1);
                    n.phase    = ASQ_ST_TICK;
                end
            end else begin
                n.ext_res = s.tag_en ? w : {1'b0, w[11:0], 3'h0};
            end
        end

        // Frame end: decode one 16-bit word
        if (cs_rise && s.rcnt >= 5'(`ASQ_FRAME_BITS)) begin
            if (!s.rx[15]) begin
                n.scan   = s.rx[`ASQ_SCAN_MSB:`ASQ_SCAN_LSB];
                n.chsel  = s.rx[`ASQ_CHSEL_MSB:`ASQ_CHSEL_LSB];
                n.tag_en = s.rx[`ASQ_TAG_BIT];
                n.software_convert_bit  = s.rx[`ASQ_SOFTWARE_CONVERT_BIT_BIT];
                n.mux    = asq_first(n.scan, n.chsel, s.cust, s.seq_mem[0]);
                n.seq_idx = '0;
                if (s.rx[`ASQ_RST_MSB:`ASQ_RST_LSB] != 2'h0) begin
                    n.wr      = '0;
                    n.rd      = '0;
                    n.cnt     = '0;
                    n.byte_lo = 1'b0;
                end
                if (s.rx[`ASQ_RST_MSB:`ASQ_RST_LSB] == `ASQ_RST_ALL) begin
                    n.scan      = `ASQ_SCAN_DEF;
                    n.chsel     = `ASQ_CHSEL_DEF;
                    n.tag_en    = 1'b0;
                    n.software_convert_bit     = 1'b0;
                    n.cfg       = '0;
                    n.cust      = '0;
                    n.seq_len   = '0;
                    n.echo_pend = 1'b0;
                    n.phase     = ASQ_ST_IDLE;
                    n.mux       = `ASQ_CHSEL_DEF;
                end
            end else begin
                case (s.rx[15:11])
                    `ASQ_SEL_CFG: begin
                        n.cfg       = s.rx[10:0];
                        n.echo_pend = s.rx[`ASQ_CFG_ECHO_BIT];
                    end
                    `ASQ_SEL_CUST0: n.cust[15:8] = s.rx[`ASQ_CUST_MSB:`ASQ_CUST_LSB];
                    `ASQ_SEL_CUST1: n.cust[7:0]  = s.rx[`ASQ_CUST_MSB:`ASQ_CUST_LSB];
                    `ASQ_SEL_SEQ: begin
                        sidx = s.rx[`ASQ_SEQ_RESTART_BIT] ? '0 : s.seq_len[`ASQ_SEQ_AW-1:0];
                        if (s.rx[`ASQ_SEQ_RESTART_BIT] || s.seq_len != 9'(`ASQ_SEQ_DEPTH)) begin
                            n.seq_mem[sidx] = s.rx[3:0];
                            n.seq_len = 9'({1'b0, sidx} + 9'h001);
                        end
                    end
                    default: n.cfg = s.cfg;
                endcase
            end
        end

        // Internal scan start
        if ((n.scan == ASQ_REPEAT || n.scan == ASQ_STD_INT || n.scan == ASQ_UP_INT || n.scan == ASQ_CUST_INT) &&
            s.phase == ASQ_ST_IDLE && ((cnv_rise && s.lvl[0] && s.cnv_low >= CNV_MIN) ||
             (cs_rise && n.software_convert_bit && !s.rx[15]))) begin
            n.eoc_n    = 1'b1;
            n.mux      = asq_first(n.scan, n.chsel, s.cust, s.seq_mem[0]);
            n.rep_left = s.cfg[`ASQ_CFG_REP_MSB:`ASQ_CFG_REP_LSB];
            n.phase    = ASQ_ST_TICK;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s       <= '0;
            s.sy    <= {4{3'h7}};
            s.lvl   <= 4'hF;
            s.scan  <= `ASQ_SCAN_DEF;
            s.chsel <= `ASQ_CHSEL_DEF;
            s.eoc_n <= 1'b1;
            s.phase <= ASQ_ST_IDLE;
        end else begin
            s <= n;
        end
    end

    assign result_ready_out = (s.buf_cnt != 2'h2);
    assign dout_out         = s.tx[15];
    assign eoc_n_out        = s.eoc_n;
    assign sample_out       = s.sample;
    assign mux_chan_out     = s.mux;
    assign fifo_count_out   = s.cnt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence frame_open;
        cs_fall;
    endsequence
    sequence scan_end;
        drain && s.phase == ASQ_ST_WAIT && !n.eoc_n;
    endsequence

    a_eoc_low_hold: assert property (!s.eoc_n && !cs_fall && !cnv_fall && !cnv_rise |=> !s.eoc_n)
        else $error("end of conversion released early");
    a_fifo_bound: assert property (s.cnt <= FIFO_FULL)
        else $error("fifo count above depth");
    a_empty_zero: assert property (frame_open and (is_int && !s.echo_pend && s.cnt == 5'h00)
                                   |=> !dout_out [*2])
        else $error("empty fifo did not read zero");
    a_scan_clear: assert property (scan_end |=> !s.software_convert_bit && !s.eoc_n && s.phase == ASQ_ST_IDLE)
        else $error("scan end did not clear convert bit");
    a_ext_sample: assert property (frame_open and !is_int |=> sample_out && mux_chan_out == $past(s.mux))
        else $error("external frame did not sample");
    a_mux_step: assert property (is_ext_scan && !step13 && !cs_rise |=> $stable(s.mux))
        else $error("mux moved outside thirteenth fall");
    a_scan_start: assert property (is_int && s.phase == ASQ_ST_IDLE && cnv_rise && s.lvl[0]
                                   |=> s.eoc_n && s.phase == ASQ_ST_TICK ##[1:16] sample_out)
        else $error("convert start did not launch scan");
    a_buf_full: assert property (result_valid_in && result_ready_out |=> s.buf_cnt != 2'h0)
        else $error("accepted result lost by buffer");
    a_seq_wrap: assert property (step13 && s.scan == ASQ_SEQ && s.seq_len != '0 &&
                                 {1'b0, s.seq_idx} == 9'(s.seq_len - 9'h001) |=> s.seq_idx == '0)
        else $error("sequence did not wrap");
    a_pop_oldest: assert property (frame_open and (is_int && !s.echo_pend && s.cnt != 5'h00 && !s.byte_lo)
                                   |=> dout_out == $past(s.fifo_mem[s.rd][15]))
        else $error("readout not oldest byte");

endmodule : asq_sequencer

// ---- common/asq_regs.svh ----
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH

// Serial frame
`define ASQ_FRAME_BITS      16
`define ASQ_MUX_STEP_FALL   13
`define ASQ_BYTE_BITS       8

// Storage sizes
`define ASQ_FIFO_DEPTH      16
`define ASQ_FIFO_AW         4
`define ASQ_SEQ_DEPTH       256
`define ASQ_SEQ_AW          8

// Register selects, bits 15:11 of a frame with bit 15 set
`define ASQ_SEL_CFG         5'h10
`define ASQ_SEL_CUST0       5'h14
`define ASQ_SEL_CUST1       5'h15
`define ASQ_SEL_SEQ         5'h16

// Mode control fields
`define ASQ_SCAN_MSB        14
`define ASQ_SCAN_LSB        11
`define ASQ_CHSEL_MSB       10
`define ASQ_CHSEL_LSB       7
`define ASQ_RST_MSB         6
`define ASQ_RST_LSB         5
`define ASQ_TAG_BIT         2
`define ASQ_SOFTWARE_CONVERT_BIT_BIT       1
`define ASQ_RST_FIFO        2'h1
`define ASQ_RST_ALL         2'h2
`define ASQ_SCAN_DEF        4'h1
`define ASQ_CHSEL_DEF       4'h0

// Configuration, custom scan and sequence fields
`define ASQ_CFG_ECHO_BIT    2
`define ASQ_CFG_REP_MSB     6
`define ASQ_CFG_REP_LSB     3
`define ASQ_CUST_MSB        10
`define ASQ_CUST_LSB        3
`define ASQ_SEQ_RESTART_BIT 10

// Timing
`define ASQ_CLK_KHZ         200000
`define ASQ_OSC_KHZ         13330
`define ASQ_OSC_TOL_PCT     15
`define ASQ_OSC_DIV         (`ASQ_CLK_KHZ / `ASQ_OSC_KHZ)
`define ASQ_CNV_LOW_NS      5
`define ASQ_CNV_LOW_CYC     ((`ASQ_CNV_LOW_NS * `ASQ_CLK_KHZ + 999999) / 1000000)

`endif

// ---- common/asq_pkg.sv ----
package asq_pkg;
`include "asq_regs.svh"

    typedef enum logic [3:0] {
        ASQ_MANUAL   = 4'h1,
        ASQ_REPEAT   = 4'h2,
        ASQ_STD_INT  = 4'h3,
        ASQ_STD_EXT  = 4'h4,
        ASQ_UP_INT   = 4'h5,
        ASQ_UP_EXT   = 4'h6,
        ASQ_CUST_INT = 4'h7,
        ASQ_CUST_EXT = 4'h8,
        ASQ_SEQ      = 4'h9
    } asq_scan_t;

    typedef enum logic [1:0] {
        ASQ_ST_IDLE,
        ASQ_ST_TICK,
        ASQ_ST_WAIT
    } asq_phase_t;

    typedef struct packed {
        logic [3:0]  chan;
        logic [11:0] data;
    } asq_word_t;

    typedef struct packed {
        logic [3:0][2:0]                         sy;
        logic [3:0]                              lvl;
        logic [2:0]                              cnv_low;
        logic [15:0]                             rx;
        logic [15:0]                             tx;
        logic [4:0]                              rcnt;
        logic [4:0]                              fcnt;
        logic [3:0]                              scan;
        logic [3:0]                              chsel;
        logic                                    tag_en;
        logic                                    software_convert_bit;
        logic [10:0]                             cfg;
        logic [15:0]                             cust;
        logic [`ASQ_SEQ_AW:0]                    seq_len;
        logic [`ASQ_SEQ_AW-1:0]                  seq_idx;
        logic [`ASQ_SEQ_DEPTH-1:0][3:0]          seq_mem;
        logic [`ASQ_FIFO_DEPTH-1:0][15:0]        fifo_mem;
        logic [`ASQ_FIFO_AW-1:0]                 wr;
        logic [`ASQ_FIFO_AW-1:0]                 rd;
        logic [`ASQ_FIFO_AW:0]                   cnt;
        logic                                    byte_lo;
        logic [1:0][15:0]                        buf_mem;
        logic                                    buf_wr;
        logic                                    buf_rd;
        logic [1:0]                              buf_cnt;
        logic [15:0]                             ext_res;
        logic                                    echo_pend;
        logic                                    echo_fr;
        asq_phase_t                              phase;
        logic [3:0]                              mux;
        logic [3:0]                              conv_chan;
        logic [3:0]                              rep_left;
        logic [3:0]                              osc_cnt;
        logic                                    eoc_n;
        logic                                    sample;
    } asq_state_t;

endpackage : asq_pkg

// ---- testbench/asq_host_model.sv ----
`timescale 1ns/1ps
module asq_host_model (
    input  wire logic clk_in,
    input  wire logic dout_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    // 80 ns half period of the link clock, in system clocks
    localparam int HALF = 16;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out  = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_clk
    // Entered at a falling system clock edge; select stays low far beyond 17 clocks
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        cs_n_out = 1'b0;
        wait_clk(HALF);
        for (int i = 15; i >= 0; i--) begin
            rx[i]    = dout_in;
            sclk_out = 1'b0;
            din_out  = tx[i];
            wait_clk(HALF);
            sclk_out = 1'b1;
            wait_clk(HALF);
        end
        cs_n_out = 1'b1;
        // Released data line must not keep showing the last bit
        din_out  = ~din_out;
        wait_clk(HALF);
    endtask : frame
endmodule : asq_host_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import asq_pkg::*;
    typedef struct {
        asq_scan_t  scan;
        logic [3:0] chsel, first, step;
    } asq_row_t;
    asq_row_t    rows[4] = '{'{ASQ_STD_INT, 4'h2, 4'h0, 4'h1}, '{ASQ_UP_INT, 4'hD, 4'hD, 4'h1},
                             '{ASQ_REPEAT, 4'h5, 4'h5, 4'h0}, '{ASQ_CUST_INT, 4'h0, 4'h1, 4'h2}};
    logic        clk_in = 1'b0, rst_in = 1'b1, cnv_n = 1'b1, valid = 1'b0, took = 1'b0;
    logic        cs_n, sclk, din, ready, dout, eoc_n, sample;
    logic [11:0] res = 12'h000;
    logic [3:0]  mux, ch;
    logic [4:0]  count;
    logic [15:0] rx;
    int          bad_count = 0, total_checks = 0, cycles = 0;
    always #2.5 clk_in = ~clk_in;
    asq_sequencer i_dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
        .convert_start_n_in(cnv_n), .result_in(res), .result_valid_in(valid), .result_ready_out(ready),
        .dout_out(dout), .eoc_n_out(eoc_n), .sample_out(sample), .mux_chan_out(mux), .fifo_count_out(count));
    asq_host_model i_host (.clk_in(clk_in), .dout_in(dout), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
    // Analog core stand-in: result carries its channel so order is visible
    always @(posedge clk_in) took <= valid && ready;
    always @(negedge clk_in) begin
        if (took) valid <= 1'b0;
        if (sample) begin
            res   <= {8'hA5, mux};
            valid <= 1'b1;
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] mode_w(input logic [3:0] scan, chsel, input logic [1:0] rst,
                                           input logic tag, sw);
        return {1'b0, scan, chsel, rst, 2'b00, tag, sw, 1'b0};
    endfunction : mode_w
    task automatic wr(input logic [15:0] w);
        i_host.frame(w, rx);
    endtask : wr
    task automatic wait_eoc;
        int n;
        n = 0;
        while (eoc_n !== 1'b0 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        check(eoc_n, 1'b0);
    endtask : wait_eoc
    // Host waits for end of conversion before anything else
    task automatic start;
        cnv_n = 1'b0;
        repeat (2) @(negedge clk_in);
        cnv_n = 1'b1;
        repeat (6) @(negedge clk_in);
        check(eoc_n, 1'b1);
        wait_eoc();
    endtask : start
    initial begin
        repeat (6) @(negedge clk_in);
        check({dout, eoc_n, sample, ready, count, mux}, {4'b0101, 5'h00, 4'h0});
        rst_in = 1'b0;
        @(negedge clk_in);
        wr({5'h10, 11'h010});
        wr({5'h14, 11'h000});
        wr({5'h15, 11'h150});
        foreach (rows[r]) begin
            wr(mode_w(rows[r].scan, rows[r].chsel, 2'h1, 1'b0, 1'b0));
            start();
            check(count, 5'h03);
            ch = rows[r].first;
            for (int k = 0; k < 4; k++) begin
                i_host.frame(16'hFFFF, rx);
                check(rx, k < 3 ? {ch, 8'hA5, ch} : 16'h0000);
                ch = ch + rows[r].step;
            end
            check(eoc_n, 1'b1);
        end
        wr({5'h10, 11'h07C});
        i_host.frame(16'hFFFF, rx);
        check(rx, 16'h807C);
        wr(mode_w(ASQ_REPEAT, 4'h9, 2'h0, 1'b0, 1'b0));
        start();
        start();
        check(count, 5'h10);
        wr(mode_w(ASQ_REPEAT, 4'h9, 2'h1, 1'b0, 1'b0));
        check(count, 5'h00);
        wr(mode_w(ASQ_STD_INT, 4'h0, 2'h0, 1'b0, 1'b1));
        wait_eoc();
        check(count, 5'h01);
        i_host.frame(16'hFFFF, rx);
        check(rx, 16'h0A50);
        wr(mode_w(ASQ_MANUAL, 4'h0, 2'h2, 1'b0, 1'b0));
        wr(mode_w(ASQ_MANUAL, 4'h7, 2'h0, 1'b1, 1'b0));
        i_host.frame(16'hFFFF, rx);
        check(mux, 4'h7);
        i_host.frame(16'hFFFF, rx);
        check(rx, 16'h7A57);
        wr({5'h16, 11'h403});
        wr({5'h16, 11'h00B});
        wr(mode_w(ASQ_SEQ, 4'h0, 2'h0, 1'b1, 1'b0));
        check(mux, 4'h3);
        for (int k = 0; k < 3; k++) begin
            i_host.frame(16'hFFFF, rx);
            check(mux, k == 1 ? 4'h3 : 4'hB);
        end
        wr(mode_w(ASQ_UP_EXT, 4'hE, 2'h0, 1'b1, 1'b0));
        for (int k = 0; k < 2; k++) begin
            i_host.frame(16'hFFFF, rx);
            check(mux, k == 0 ? 4'hF : 4'hE);
        end
        end_of_test();
    end
endmodule : tb_top
